// ==== rtl/sssx_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SSSX_MAP_SVH
`define SSSX_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSSX_OFF_CMD 8'h00
`define SSSX_OFF_ACC 8'h04
`define SSSX_OFF_FLAGS 8'h08
`define SSSX_OFF_STATUS 8'h0C
`define SSSX_MEM_BASE_HI 2'h1
`define SSSX_MEM_WORDS 16

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define SSSX_CMD_OP_LSB 0
`define SSSX_CMD_OP_MSB 2
`define SSSX_CMD_ADR_LSB 4
`define SSSX_CMD_ADR_MSB 7
`define SSSX_CMD_IMM_LSB 8
`define SSSX_CMD_IMM_MSB 15

// ----------------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------------
`define SSSX_FLAG_C 0
`define SSSX_FLAG_AC 1
`define SSSX_FLAG_Z 2
`define SSSX_FLAG_OV 3
`define SSSX_FLAG_SC 4
`define SSSX_FLAG_CZ 5

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SSSX_STAT_BUSY 0
`define SSSX_STAT_SKIP 1
`define SSSX_STAT_ILLEGAL 2
`define SSSX_STAT_CYC_LSB 4
`define SSSX_STAT_CYC_MSB 5
`define SSSX_STAT_CNT_LSB 8
`define SSSX_STAT_CNT_MSB 15

// ----------------------------------------------------------------------
// Reset values and cycle counts
// ----------------------------------------------------------------------
`define SSSX_RST_BYTE 8'h00
`define SSSX_CYCLES_PLAIN 2'h1
`define SSSX_CYCLES_SKIP 2'h2

`endif

// ==== rtl/sssx_pkg.sv ====
// Types shared by the subtract, swap and skip execution unit
package sssx_pkg;

  // Operation codes carried in the command register
  typedef enum logic [2:0] {
    SSSX_OP_NONE = 3'b000,
    SSSX_OP_SKIP_NZ = 3'b001,     // skip_if_nonzero_op
    SSSX_OP_SUB_ACC = 3'b010,     // Memory from accumulator, into acc
    SSSX_OP_SUB_MEM = 3'b011,     // subtract_into_memory_op
    SSSX_OP_SUB_IMM = 3'b100,     // Immediate from accumulator
    SSSX_OP_SWAP_MEM = 3'b101,    // Nibble swap in place
    SSSX_OP_SWAP_ACC = 3'b110,    // nibble_exchange_to_acc_op
    SSSX_OP_RSVD = 3'b111
  } sssx_op_type;

  // Execution sequencer states
  typedef enum logic [1:0] {
    SSSX_ST_IDLE = 2'b00,
    SSSX_ST_EXEC = 2'b01,
    SSSX_ST_DUMMY = 2'b10
  } sssx_state_type;

  // Status flags touched by the subtract forms
  typedef struct packed {
    logic cascaded_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } sssx_flags_type;

  // Result of the datapath for one instruction
  typedef struct packed {
    logic [7:0] value;
    sssx_flags_type flags;
  } sssx_alu_out_type;

endpackage : sssx_pkg

// ==== rtl/sssx_alu.sv ====
// Combinational subtract and nibble swap datapath
`timescale 1ns/1ps
module sssx_alu
  import sssx_pkg::*;
(
  input wire sssx_pkg::sssx_op_type op_i,    // Operation in flight
  input wire logic [7:0] acc_i,              // Accumulator value
  input wire logic [7:0] operand_i,          // Memory byte or immediate
  output sssx_pkg::sssx_alu_out_type res_o   // Value and new flags
);

  // --------------------------------------------------------------------
  // Subtraction with borrow tracking
  // --------------------------------------------------------------------
  logic [8:0] wide_diff;   // Bit 8 is the borrow out
  logic [4:0] half_diff;   // Bit 4 is the borrow out of the low nibble
  logic ovf;               // Signed overflow of acc minus operand

  // Widen by one bit so the borrow falls out of the subtraction itself
  assign wide_diff = {1'b0, acc_i} - {1'b0, operand_i};
  assign half_diff = {1'b0, acc_i[3:0]} - {1'b0, operand_i[3:0]};
  assign ovf = (acc_i[7] ^ operand_i[7]) & (acc_i[7] ^ wide_diff[7]);

  // --------------------------------------------------------------------
  // Result selection
  // --------------------------------------------------------------------
  // Swap forms only produce a value; flags field is don't-care for them
  always_comb
  begin
    res_o.value = wide_diff[7:0];
    // Borrow means negative difference, so carry is its inverse
    res_o.flags.carry_flag = ~wide_diff[8];
    res_o.flags.aux_carry_flag = ~half_diff[4];
    res_o.flags.zero_flag = (wide_diff[7:0] == 8'h00);
    res_o.flags.overflow_flag = ovf;
    // Set when acc is signed greater or equal to the operand
    res_o.flags.signed_compare_flag = ~(ovf ^ wide_diff[7]);
    // Single byte subtract: cascaded zero follows plain zero
    res_o.flags.cascaded_zero_flag = (wide_diff[7:0] == 8'h00);
    if (op_i == SSSX_OP_SWAP_MEM || op_i == SSSX_OP_SWAP_ACC)
    begin
      // High and low nibbles trade places
      res_o.value = {operand_i[3:0], operand_i[7:4]};
    end
  end

endmodule : sssx_alu

// ==== rtl/sssx_exec.sv ====
// Execution unit for skip, subtract and nibble swap with Wishbone access
`timescale 1ns/1ps
`include "sssx_map.svh"

module sssx_exec
  import sssx_pkg::*;
(
  input wire logic REF_CLK_I,           // 40 MHz core clock
  input wire logic NRST_I,              // Asynchronous reset, active low
  input wire logic WB_CYC_I,            // Wishbone cycle
  input wire logic WB_STB_I,            // Wishbone strobe
  input wire logic WB_WE_I,             // Wishbone write enable
  input wire logic [7:0] WB_ADR_I,      // Wishbone byte address
  input wire logic [3:0] WB_SEL_I,      // Wishbone byte lanes
  input wire logic [31:0] WB_DAT_I,     // Wishbone write data
  output logic [31:0] WB_DAT_O,         // Wishbone read data
  output logic WB_ACK_O,                // Wishbone acknowledge
  output logic BUSY_O,                  // Instruction in progress
  output logic SKIP_O                   // Dummy cycle of a taken skip
);
  import sssx_pkg::*;

  // --------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------
  logic rst_meta_n;  // First stage, read only by the second
  logic rst_n;       // Released copy used by all other logic

  // Release is synchronised so no flop leaves reset on a split edge
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  sssx_state_type state;        // Sequencer state
  sssx_op_type cmd_op;          // Latched operation
  logic [3:0] cmd_adr;          // Latched memory address
  logic [7:0] cmd_imm;          // Latched immediate constant
  logic [7:0] acc;              // Accumulator
  sssx_flags_type flags;        // Status flags
  logic [7:0] mem [0:`SSSX_MEM_WORDS-1];  // Data memory bytes
  logic skip_taken;             // Last executed instruction was a taken skip
  logic illegal;                // Last command code was not executable
  logic [1:0] last_cycles;      // Cycles used by last instruction
  logic [7:0] instr_count;      // Executed instructions, wraps
  sssx_alu_out_type alu_res;    // Datapath answer
  logic [7:0] operand;          // Memory byte or immediate
  logic [7:0] mem_byte;         // Addressed memory byte

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Decoding used by the flag update path
  function automatic logic is_sub(input sssx_op_type op);
    is_sub = (op == SSSX_OP_SUB_ACC) || (op == SSSX_OP_SUB_MEM) ||
             (op == SSSX_OP_SUB_IMM);
  endfunction : is_sub

  // Codes that the sequencer will run
  function automatic logic is_legal(input logic [2:0] code);
    is_legal = (code != 3'h0) && (code != 3'h7);
  endfunction : is_legal

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic bus_req;     // New request this cycle
  logic bus_wr;      // Write accepted this cycle
  logic mem_hit;     // Address falls in data memory window
  logic [3:0] mem_idx;  // Data memory word index
  logic exec_now;    // Sequencer performs the operation this cycle
  logic cmd_wr;      // Command register written while idle

  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];
  assign mem_hit = (WB_ADR_I[7:6] == `SSSX_MEM_BASE_HI);
  assign mem_idx = WB_ADR_I[5:2];
  assign exec_now = (state == SSSX_ST_EXEC);
  // Commands arriving while busy are dropped, so one runs at a time
  assign cmd_wr = bus_wr & (WB_ADR_I == `SSSX_OFF_CMD) &
                  (state == SSSX_ST_IDLE);

  // --------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------
  assign mem_byte = mem[cmd_adr];
  assign operand = (cmd_op == SSSX_OP_SUB_IMM) ? cmd_imm : mem_byte;

  sssx_alu sssx_alu_inst (
    .op_i(cmd_op),
    .acc_i(acc),
    .operand_i(operand),
    .res_o(alu_res)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Idle until a command, one execute cycle, then a dummy cycle only
  // when a skip is taken
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= SSSX_ST_IDLE;
    end
    else
    begin
      unique case (state)
        SSSX_ST_IDLE:
        begin
          if (cmd_wr && is_legal(WB_DAT_I[2:0]))
          begin
            state <= SSSX_ST_EXEC;
          end
        end
        SSSX_ST_EXEC:
        begin
          if (cmd_op == SSSX_OP_SKIP_NZ && mem_byte != 8'h00)
          begin
            state <= SSSX_ST_DUMMY;
          end
          else
          begin
            state <= SSSX_ST_IDLE;
          end
        end
        SSSX_ST_DUMMY:
        begin
          // Stands in for the skipped fetch
          state <= SSSX_ST_IDLE;
        end
        default:
        begin
          state <= SSSX_ST_IDLE;     // Unused code recovers to idle
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Command latch and completion status
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_op <= SSSX_OP_NONE;
      cmd_adr <= 4'h0;
      cmd_imm <= `SSSX_RST_BYTE;
      illegal <= 1'b0;
      skip_taken <= 1'b0;
      last_cycles <= 2'h0;
      instr_count <= 8'h00;
    end
    else
    begin
      if (cmd_wr)
      begin
        // Command fields are kept for read-back
        cmd_op <= sssx_op_type'(WB_DAT_I[`SSSX_CMD_OP_MSB:`SSSX_CMD_OP_LSB]);
        cmd_adr <= WB_DAT_I[`SSSX_CMD_ADR_MSB:`SSSX_CMD_ADR_LSB];
        cmd_imm <= WB_DAT_I[`SSSX_CMD_IMM_MSB:`SSSX_CMD_IMM_LSB];
        illegal <= ~is_legal(WB_DAT_I[2:0]);
      end
      if (exec_now)
      begin
        instr_count <= instr_count + 8'h01;
        if (cmd_op == SSSX_OP_SKIP_NZ && mem_byte != 8'h00)
        begin
          skip_taken <= 1'b1;
          last_cycles <= `SSSX_CYCLES_SKIP;
        end
        else
        begin
          skip_taken <= 1'b0;
          last_cycles <= `SSSX_CYCLES_PLAIN;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Accumulator
  // --------------------------------------------------------------------
  // Execution and bus writes cannot meet: bus writes need idle state
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc <= `SSSX_RST_BYTE;
    end
    else if (exec_now)
    begin
      if (cmd_op == SSSX_OP_SUB_ACC || cmd_op == SSSX_OP_SUB_IMM ||
          cmd_op == SSSX_OP_SWAP_ACC)
      begin
        acc <= alu_res.value;
      end
    end
    else if (bus_wr && state == SSSX_ST_IDLE &&
             WB_ADR_I == `SSSX_OFF_ACC)
    begin
      acc <= WB_DAT_I[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= sssx_flags_type'(6'h00);
    end
    else if (exec_now)
    begin
      // Swap and skip leave flags alone
      if (is_sub(cmd_op))
      begin
        flags <= alu_res.flags;
      end
    end
    else if (bus_wr && state == SSSX_ST_IDLE &&
             WB_ADR_I == `SSSX_OFF_FLAGS)
    begin
      flags <= sssx_flags_type'(WB_DAT_I[5:0]);
    end
  end

  // --------------------------------------------------------------------
  // Data memory
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `SSSX_MEM_WORDS; i++)
      begin
        mem[i] <= `SSSX_RST_BYTE;
      end
    end
    else if (exec_now)
    begin
      if (cmd_op == SSSX_OP_SKIP_NZ)
      begin
        mem[cmd_adr] <= mem_byte;       // Rewritten unchanged
      end
      else if (cmd_op == SSSX_OP_SUB_MEM || cmd_op == SSSX_OP_SWAP_MEM)
      begin
        mem[cmd_adr] <= alu_res.value;
      end
    end
    else if (bus_wr && state == SSSX_ST_IDLE && mem_hit)
    begin
      mem[mem_idx] <= WB_DAT_I[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Wishbone answer
  // --------------------------------------------------------------------
  // Every access, mapped or not, is acked one cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I)
      begin
        WB_DAT_O <= 32'h0000_0000;  // Unmapped reads give zero
        if (mem_hit)
        begin
          WB_DAT_O[7:0] <= mem[mem_idx];
        end
        else
        begin
          unique case (WB_ADR_I)
            `SSSX_OFF_CMD:
            begin
              WB_DAT_O[15:0] <= {cmd_imm, cmd_adr, 1'b0, cmd_op};
            end
            `SSSX_OFF_ACC:
            begin
              WB_DAT_O[7:0] <= acc;
            end
            `SSSX_OFF_FLAGS:
            begin
              WB_DAT_O[5:0] <= flags;
            end
            `SSSX_OFF_STATUS:
            begin
              WB_DAT_O[15:0] <= {instr_count, 2'b00, last_cycles, 1'b0,
                                 illegal, skip_taken,
                                 (state != SSSX_ST_IDLE)};
            end
            default:
            begin
              WB_DAT_O <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin status
  // --------------------------------------------------------------------
  assign BUSY_O = (state != SSSX_ST_IDLE);
  assign SKIP_O = (state == SSSX_ST_DUMMY);

endmodule : sssx_exec

// ==== tb/sssx_exec_asserts.sv ====
// Port assertions for the skip, subtract and swap execution unit
`timescale 1ns/1ps
module sssx_exec_asserts
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic BUSY_O,
  input wire logic SKIP_O
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic take;      // Bus request accepted on this edge
  logic req_take;  // Request accepted on the previous edge
  logic cmd_take;  // Legal command accepted while idle
  logic rd_take;   // Read of the unmapped word at 0x10 accepted
  logic rd_any;    // Any read accepted
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Remember accepted requests so answers can be tied to their cause
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      req_take <= 1'b0;
      cmd_take <= 1'b0;
      rd_take <= 1'b0;
      rd_any <= 1'b0;
    end
    else
    begin
      req_take <= take;
      // Ops 0 and 7 are refused, so they must never start the sequencer
      cmd_take <= take && WB_WE_I && WB_SEL_I[0] && !BUSY_O &&
                  (WB_ADR_I == 8'h00) && (WB_DAT_I[2:0] != 3'h0) &&
                  (WB_DAT_I[2:0] != 3'h7);
      rd_take <= take && !WB_WE_I && (WB_ADR_I == 8'h10);
      rd_any <= take && !WB_WE_I;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ack_follows_req: assert property (take |=> WB_ACK_O)
    else $error("acknowledge missing after request");
  a_ack_single_pulse: assert property (WB_ACK_O |-> req_take ##1 !WB_ACK_O)
    else $error("acknowledge not a single answering pulse");
  a_cmd_starts_exec: assert property
    (cmd_take |-> BUSY_O && !SKIP_O)
    else $error("command did not start execution");
  a_busy_from_cmd: assert property ($rose(BUSY_O) |-> cmd_take)
    else $error("busy rose without a legal command");
  a_exec_one_cycle: assert property
    ($rose(BUSY_O) |=> !BUSY_O || SKIP_O)
    else $error("execution cycle longer than one");
  a_skip_inside_busy: assert property (SKIP_O |-> BUSY_O)
    else $error("dummy cycle outside busy");
  a_skip_two_cycles: assert property (SKIP_O |=> !BUSY_O && !SKIP_O)
    else $error("taken skip longer than two cycles");
  a_skip_after_exec: assert property
    ($rose(SKIP_O) |-> $past(BUSY_O) && !$past(SKIP_O))
    else $error("dummy cycle not after an execution cycle");
  a_unmapped_zero: assert property (rd_take |-> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_read_high_zero: assert property (rd_any |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("unused read bits not zero");
endmodule : sssx_exec_asserts

bind sssx_exec sssx_exec_asserts sssx_exec_asserts_inst (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .BUSY_O(BUSY_O), .SKIP_O(SKIP_O)
);

// ==== tb/tb.sv ====
// Self-checking bench for the skip, subtract and swap execution unit
`timescale 1ns/1ps
`include "sssx_map.svh"
module tb;
  import sssx_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------------------------------------
  logic REF_CLK_I = 1'b0;
  logic NRST_I = 1'b0;      // Reset held from time zero
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0000_0000;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic BUSY_O;
  logic SKIP_O;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] exp_cnt = 8'h00;  // Executed instruction count we expect

  sssx_exec sssx_exec_inst (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .BUSY_O(BUSY_O), .SKIP_O(SKIP_O)
  );

  // 40 MHz clock
  always #12.5 REF_CLK_I = ~REF_CLK_I;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic single cycle; starts after an edge so strobe drops one cycle
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge REF_CLK_I);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= wdat;
    @(posedge REF_CLK_I);
    // No local limit: only the watchdog ends a wait for the answer
    while (WB_ACK_O !== 1'b1)
    begin
      @(posedge REF_CLK_I);
      n++;
    end
    // Acknowledge is due one cycle after the request is taken
    check("ack wait", 32'(n), 32'h0000_0001);
    rdat = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, 32'(dat), d);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    bus(1'b0, adr, 32'h0000_0000, d);
  endtask : rd

  function automatic logic [7:0] madr(input logic [3:0] idx);
    madr = {`SSSX_MEM_BASE_HI, idx, 2'b00};
  endfunction : madr

  // Issue one command, count busy cycles, then check the status word
  task automatic run(input logic [2:0] op, input logic [3:0] idx,
                     input logic [7:0] imm, input logic [1:0] cyc_e);
    logic [31:0] d;
    logic [1:0] cyc;
    logic sk;
    bus(1'b1, `SSSX_OFF_CMD, {16'h0000, imm, idx, 1'b0, op}, d);
    cyc = 2'h1;
    sk = 1'b0;
    repeat (3)
    begin
      @(negedge REF_CLK_I);
      if (BUSY_O === 1'b1)
        cyc++;
      if (SKIP_O === 1'b1)
        sk = 1'b1;
    end
    exp_cnt++;
    check("cycles", 32'(cyc), 32'(cyc_e));
    check("skip pin", 32'(sk), 32'(cyc_e == 2'h2));
    rd(`SSSX_OFF_STATUS, d);
    check("status", d, {16'h0000, exp_cnt, 2'b00, cyc_e, 2'b00,
          cyc_e == 2'h2, 1'b0});
  endtask : run

  // Read a byte register and compare the whole word
  task automatic expect_reg(input string name, input logic [7:0] adr,
                            input logic [7:0] exp);
    logic [31:0] d;
    rd(adr, d);
    check(name, d, 32'(exp));
  endtask : expect_reg

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    expect_reg("acc", `SSSX_OFF_ACC, 8'h00);
    expect_reg("flags", `SSSX_OFF_FLAGS, 8'h00);
    expect_reg("status", `SSSX_OFF_STATUS, 8'h00);
    expect_reg("mem", madr(4'hF), 8'h00);
    wr(8'h10, 8'h5A);  // Unmapped write must vanish
    expect_reg("unmapped", 8'h10, 8'h00);
  endtask : t_reset

  // Nonzero bytes skip in two cycles; zero continues in one
  task automatic t_skip();
    logic [7:0] v [3] = '{8'h80, 8'h01, 8'h00};
    wr(`SSSX_OFF_FLAGS, 8'h15);
    for (int i = 0; i < 3; i++)
    begin
      wr(madr(4'(i)), v[i]);
      run(SSSX_OP_SKIP_NZ, 4'(i), 8'h00, (v[i] != 8'h00) ? 2'h2 : 2'h1);
      expect_reg("skip mem", madr(4'(i)), v[i]);
      expect_reg("skip flags", `SSSX_OFF_FLAGS, 8'h15);
    end
  endtask : t_skip

  // Three subtract forms over borrow, zero, overflow and nibble cases
  task automatic t_subtract();
    logic [7:0] a_t [4] = '{8'h05, 8'h03, 8'h80, 8'h10};
    logic [7:0] b_t [4] = '{8'h05, 8'h05, 8'h01, 8'h01};
    logic [2:0] ops [3] = '{SSSX_OP_SUB_ACC, SSSX_OP_SUB_MEM,
                            SSSX_OP_SUB_IMM};
    logic [7:0] a, b, r, m, ea, em, f;
    logic ov;
    for (int k = 0; k < 3; k++)
      for (int i = 0; i < 4; i++)
      begin
        a = a_t[i];
        b = b_t[i];
        r = a - b;
        ov = (a[7] != b[7]) && (r[7] != a[7]);
        // Signed compare judged from the operands themselves
        f = {2'b00, r == 8'h00, $signed(a) >= $signed(b), ov, r == 8'h00,
             a[3:0] >= b[3:0], a >= b};
        // Decoy operand in the unused source exposes a wrong mux
        m = (k == 2) ? ~b : b;
        ea = (k == 1) ? a : r;
        em = (k == 1) ? r : m;
        wr(`SSSX_OFF_ACC, a);
        wr(madr(4'(i + 4)), m);
        wr(`SSSX_OFF_FLAGS, ~f);
        run(ops[k], 4'(i + 4), (k == 2) ? b : ~b, 2'h1);
        expect_reg("sub acc", `SSSX_OFF_ACC, ea);
        expect_reg("sub mem", madr(4'(i + 4)), em);
        expect_reg("sub flags", `SSSX_OFF_FLAGS, f);
      end
  endtask : t_subtract

  // Nibble swap in place and into the accumulator, flags untouched
  task automatic t_swap();
    wr(`SSSX_OFF_FLAGS, 8'h2A);
    wr(`SSSX_OFF_ACC, 8'h11);
    wr(madr(4'h9), 8'h3C);
    run(SSSX_OP_SWAP_MEM, 4'h9, 8'h00, 2'h1);
    expect_reg("swap mem", madr(4'h9), 8'hC3);
    expect_reg("swap acc", `SSSX_OFF_ACC, 8'h11);
    expect_reg("swap flags", `SSSX_OFF_FLAGS, 8'h2A);
    wr(madr(4'hA), 8'h5A);
    run(SSSX_OP_SWAP_ACC, 4'hA, 8'h00, 2'h1);
    expect_reg("nibble_exchange_to_acc_op acc", `SSSX_OFF_ACC, 8'hA5);
    expect_reg("nibble_exchange_to_acc_op mem", madr(4'hA), 8'h5A);
    expect_reg("nibble_exchange_to_acc_op flags", `SSSX_OFF_FLAGS, 8'h2A);
    // Command word reads back as written, bit 3 as zero
    expect_reg("cmd", `SSSX_OFF_CMD, 8'hA6);
  endtask : t_swap

  // Refused op codes flag an error and execute nothing
  task automatic t_illegal();
    logic [31:0] d;
    logic [2:0] bad [2] = '{SSSX_OP_NONE, SSSX_OP_RSVD};
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `SSSX_OFF_CMD, 32'(bad[i]), d);
      rd(`SSSX_OFF_STATUS, d);
      check("illegal", 32'({d[15:8], d[2], d[0]}), 32'({exp_cnt, 2'b10}));
    end
  endtask : t_illegal

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge REF_CLK_I);
    NRST_I <= 1'b1;
    // Let the two-flop reset release settle before the first request
    repeat (3) @(posedge REF_CLK_I);
    t_reset();
    t_skip();
    t_subtract();
    t_swap();
    t_illegal();
    stop_test();
  end

  // Whole run needs a few hundred cycles; twenty thousand means a hang
  initial
  begin
    repeat (20000) @(posedge REF_CLK_I);
    fails++;
    stop_test();
  end
endmodule : tb
